// ### core/pin_sync.sv
// Two-flop synchronisers for asynchronous inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic hold_q;
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               meta_q <= 1'b0;
               hold_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               hold_q <= meta_q;
            end
         end
         assign sync_out[i] = hold_q;
      end
   endgenerate
endmodule

// ### core/sleep_clk_ctrl.sv
// Sleep mode and clock start-up controller with classic Wishbone register slave
//
// Notes on behaviour
// (R1) Sleep with mode 10 enters power-down
// (R2) Power-down stops the oscillators; wake sources stay alive
// (R3) Only listed resets and interrupts end power-down
// (R4) Power-down gates every generated clock
// (R5) Level wake sources must hold long enough
// (R6) Wake waits start-up period from clock selection
// (R7) Mode 11 enters power-save, like power-down
// (R8) Timer zero wakes only with its enables
// (R9) Software avoids power-save without asynchronous timer clock
// (R10) Power-save keeps only the asynchronous timer clock
// (R11) Code 0010 selects the calibrated RC oscillator
// (R12) Divide-by-eight fuse divides the system clock
// (R13) Start-up: 6 cycles from sleep, 14 plus delay; the code counts the delay alongside the 14 cycles, not after them
// (R14) Start-up code 00 needs reset pin enabled
// (R15) Default start-up code 10, 65 ms delay
// (R16) 128 kHz oscillator selectable by fuse or field
// (R17) 128 kHz oscillator uses the same start-up delays
// (R18) Core clock gated until start-up count ends
`timescale 1ns/1ps
module sleep_clk_ctrl
   import sleep_clk_pkg::*;
#(
   parameter int unsigned DLY_SHORT_CYCLES = DLY_SHORT_CYC,
   parameter int unsigned DLY_LONG_CYCLES  = DLY_LONG_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sleep_exec,
   input  wire logic        timer0_async_select,
   input  wire logic        timer0_ovf_ie,
   input  wire logic        timer0_cmp_ie,
   input  wire logic        global_ie,
   input  wire wake_src_t   wake_src_i,
   input  wire logic        osc_toggle_i,
   input  wire logic [3:0]  clock_source_fuse,
   input  wire logic [1:0]  startup_time_fuse,
   input  wire logic        divide_by_eight_fuse,
   input  wire logic        reset_pin_disable_fuse,
   output clk_ctrl_t        clk_ctrl_o,
   output logic             irq_o
);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] sut_resolve(input logic [1:0] code, input logic rst_dis);
      logic [1:0] r;
      r = code;
      if (code == SUT_RSVD) begin
         r = SUT_LONG;
      end else if (code == SUT_FAST && rst_dis) begin
         r = SUT_SHORT;
      end
      return r;
   endfunction

   function automatic logic sut_illegal(input logic [1:0] code, input logic rst_dis);
      return (code == SUT_RSVD) || (code == SUT_FAST && rst_dis);
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [WAKE_W-1:0] sync_w;
   wake_src_t         ws;
   logic              osc_s;
   logic              osc_prev_q;
   logic              osc_tick;

   pin_sync #(.W(WAKE_W)) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in ({osc_toggle_i, wake_src_i}),
      .sync_out (sync_w)
   );
   assign ws    = wake_src_t'(sync_w[WAKE_W-2:0]);
   assign osc_s = sync_w[WAKE_W-1];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_s;
      end
   end
   assign osc_tick = osc_s ^ osc_prev_q;

   // ----------------------------------------------------------------
   // Fuse capture
   // ----------------------------------------------------------------
   logic       fuse_ok_q;
   logic [3:0] fuse_src_q;
   logic [1:0] fuse_sut_q;
   logic       fuse_div8_q;
   logic       fuse_rstdis_q;

   // Fuses are caught one clock after reset release, never under reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fuse_ok_q     <= 1'b0;
         fuse_src_q    <= CLOCK_SOURCE_FUSE_RESET;
         fuse_sut_q    <= SUT_RESET;
         fuse_div8_q   <= 1'b0;
         fuse_rstdis_q <= 1'b0;
      end else if (!fuse_ok_q) begin
         fuse_ok_q     <= 1'b1;
         fuse_src_q    <= clock_source_fuse;
         fuse_sut_q    <= startup_time_fuse;
         fuse_div8_q   <= divide_by_eight_fuse;
         fuse_rstdis_q <= reset_pin_disable_fuse;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [1:0]       sm_q;
   logic [3:0]       clock_source_field_q;
   logic [1:0]       startup_time_field_q;
   logic             fld_en_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_evt;
   logic             ack_q;
   logic [31:0]      rdat_q;
   logic             wb_req;
   logic             wr_ctrl;
   logic             rd_irq;
   logic [3:0]       src_eff;
   logic [1:0]       sut_eff;
   pm_state_t        state_q;
   logic [1:0]       mode_q;

   assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_ctrl = wb_req && wb_we_i && wb_adr_i == ADR_CTRL;
   assign rd_irq  = wb_req && !wb_we_i && wb_adr_i == ADR_IRQ_STAT;

   // Field overrides the fuses only while its enable bit is set
   assign src_eff = fld_en_q ? clock_source_field_q : fuse_src_q;                          // see R11 see R16
   assign sut_eff = sut_resolve(fld_en_q ? startup_time_field_q : fuse_sut_q, fuse_rstdis_q); // see R14 see R17

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sm_q     <= SM_RESET;
         clock_source_field_q   <= CLOCK_SOURCE_FUSE_RESET;                                            // see R11
         startup_time_field_q   <= SUT_RESET;                                              // see R15
         fld_en_q <= 1'b0;
      end else if (wr_ctrl) begin
         if (wb_sel_i[0]) begin
            sm_q   <= wb_dat_i[CTRL_SM_LSB +: 2];
            clock_source_field_q <= wb_dat_i[CTRL_CLOCK_SOURCE_FIELD_LSB +: 4];
         end
         if (wb_sel_i[1]) begin
            startup_time_field_q   <= wb_dat_i[CTRL_STARTUP_TIME_FIELD_LSB +: 2];
            fld_en_q <= wb_dat_i[CTRL_FLD_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_mask_q <= '0;
      end else if (wb_req && wb_we_i && wb_adr_i == ADR_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
   end

   // A read clears the status, but an event in the same cycle survives it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | irq_evt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((rd_irq ? '0 : irq_stat_q) | irq_evt) & irq_mask_q);
      end
   end

   // One-cycle answer; unmapped addresses answer with zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= wb_req;
         rdat_q <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               ADR_CTRL: begin
                  rdat_q[CTRL_SM_LSB +: 2]   <= sm_q;
                  rdat_q[CTRL_CLOCK_SOURCE_FIELD_LSB +: 4] <= clock_source_field_q;
                  rdat_q[CTRL_STARTUP_TIME_FIELD_LSB +: 2] <= startup_time_field_q;
                  rdat_q[CTRL_FLD_BIT]       <= fld_en_q;
               end
               ADR_STATUS: begin
                  rdat_q[STAT_ST_LSB +: 4]   <= state_q;
                  rdat_q[STAT_MODE_LSB +: 2] <= mode_q;
                  rdat_q[STAT_SRC_LSB +: 4]  <= src_eff;
                  rdat_q[STAT_SUT_LSB +: 2]  <= sut_eff;
                  rdat_q[STAT_DIV8_BIT]      <= fuse_div8_q;
               end
               ADR_IRQ_STAT: rdat_q[IRQ_W-1:0] <= irq_stat_q;
               ADR_IRQ_MASK: rdat_q[IRQ_W-1:0] <= irq_mask_q;
               default:      rdat_q <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   logic             rst_src;
   logic             wake_irq;
   logic             wake_t0;
   logic             launch_q;
   logic             tmr_start;
   logic             tmr_busy;
   logic             tmr_done;
   logic [4:0]       ck_tgt;
   logic [DLY_W-1:0] dly_tgt;

   assign rst_src  = ws.ext_rst || ws.wdt_rst || ws.bod_rst;                  // see R3
   assign wake_irq = ws.wdt_irq || ws.usi_start || ws.external_interrupt_zero_lvl || ws.external_interrupt_one_lvl || ws.pin_change; // see R3 see R5
   assign wake_t0  = mode_q == MODE_PSAVE && timer0_async_select && global_ie &&
                     ((ws.t0_ovf && timer0_ovf_ie) || (ws.t0_cmp && timer0_cmp_ie)); // see R8 see R9

   assign tmr_start = (state_q == ST_BOOT && launch_q && fuse_ok_q && !rst_src) ||
                      (state_q == ST_SLEEP && !rst_src && (wake_irq || wake_t0));
   assign ck_tgt    = state_q == ST_BOOT ? CK_RESET : CK_SLEEP;              // see R13 see R17
   always_comb begin
      case (sut_eff)
         SUT_SHORT: dly_tgt = DLY_W'(DLY_SHORT_CYCLES);
         SUT_LONG:  dly_tgt = DLY_W'(DLY_LONG_CYCLES);                       // see R15
         default:   dly_tgt = '0;
      endcase
      if (state_q != ST_BOOT) begin
         dly_tgt = '0;
      end
   end

   startup_timer u_tmr (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .start      (tmr_start),
      .ck_target  (ck_tgt),
      .dly_target (dly_tgt),
      .osc_tick   (osc_tick),
      .busy       (tmr_busy),
      .done       (tmr_done)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q  <= ST_BOOT;
         launch_q <= 1'b1;
         mode_q   <= SM_RESET;
      end else if (rst_src) begin
         state_q  <= ST_BOOT;
         launch_q <= 1'b1;
      end else begin
         case (state_q)
            ST_BOOT: begin
               if (tmr_start) begin
                  launch_q <= 1'b0;
               end
               // A done left over from a cut wake count must not end the boot
               if (tmr_done && !launch_q) begin
                  state_q <= ST_RUN;                                         // see R18
               end
            end
            ST_RUN: begin
               if (sleep_exec && sm_q[1]) begin
                  state_q <= ST_SLEEP;                                       // see R1 see R7
                  mode_q  <= sm_q;
               end
            end
            ST_SLEEP: begin
               if (tmr_start) begin
                  state_q <= ST_WAKE;                                        // see R3 see R6
               end
            end
            ST_WAKE: begin
               if (tmr_done) begin
                  state_q <= ST_RUN;                                         // see R18
               end
            end
            default: begin
               state_q  <= ST_BOOT;
               launch_q <= 1'b1;
            end
         endcase
      end
   end

   assign irq_evt[IRQ_SLEEP] = state_q == ST_RUN && sleep_exec && sm_q[1] && !rst_src;
   assign irq_evt[IRQ_WAKE]  = state_q == ST_WAKE && tmr_done && !rst_src;
   assign irq_evt[IRQ_RSVD]  = tmr_start && state_q == ST_BOOT &&
                               sut_illegal(fld_en_q ? startup_time_field_q : fuse_sut_q, fuse_rstdis_q); // see R14

   // ----------------------------------------------------------------
   // Clock gating outputs
   // ----------------------------------------------------------------
   logic osc_on;
   assign osc_on = state_q != ST_SLEEP;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clk_ctrl_o <= '0;
      end else begin
         clk_ctrl_o.core_clk_en  <= state_q == ST_RUN && !rst_src;           // see R4 see R18
         clk_ctrl_o.rc_osc_en    <= osc_on && src_eff == CLOCK_SOURCE_FUSE_RC;           // see R2 see R11
         clk_ctrl_o.lp_osc_en    <= osc_on && src_eff == CLOCK_SOURCE_FUSE_LP;           // see R16
         clk_ctrl_o.ext_osc_en   <= osc_on && src_eff != CLOCK_SOURCE_FUSE_RC && src_eff != CLOCK_SOURCE_FUSE_LP; // see R2
         clk_ctrl_o.async_clk_en <= timer0_async_select &&
                                    (osc_on || mode_q == MODE_PSAVE);        // see R10
         clk_ctrl_o.div8_en      <= fuse_div8_q;                             // see R12
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic [4:0] wake_ticks_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n || state_q != ST_WAKE) begin
         wake_ticks_q <= 5'h00;
      end else if (osc_tick && wake_ticks_q != 5'h1F) begin
         wake_ticks_q <= wake_ticks_q + 5'h01;
      end
   end

   AST_SLEEP_ENTRY: assert property (state_q == ST_RUN && sleep_exec && sm_q[1] && !rst_src // see R1 see R7
      |=> state_q == ST_SLEEP && mode_q == $past(sm_q))
      else $error("Sleep request not taken");
   AST_CORE_GATED: assert property (clk_ctrl_o.core_clk_en |-> $past(state_q) == ST_RUN) // see R4 see R18
      else $error("Core clock running outside run state");
   AST_OSC_STOPPED: assert property (state_q == ST_SLEEP [*2] // see R2
      |-> !clk_ctrl_o.rc_osc_en && !clk_ctrl_o.lp_osc_en && !clk_ctrl_o.ext_osc_en)
      else $error("Oscillator running in sleep");
   AST_ASYNC_CLK: assert property (state_q == ST_SLEEP [*2] // see R10
      |-> clk_ctrl_o.async_clk_en == ($past(timer0_async_select) && mode_q == MODE_PSAVE))
      else $error("Asynchronous timer clock wrong in sleep");
   AST_NO_SPURIOUS_WAKE: assert property (state_q == ST_SLEEP && !wake_irq && !wake_t0 && !rst_src // see R3
      |=> state_q == ST_SLEEP)
      else $error("Left sleep without wake source");
   AST_T0_WAKE: assert property (state_q == ST_SLEEP && !rst_src && wake_t0 // see R8
      |=> state_q == ST_WAKE ##1 clk_ctrl_o.rc_osc_en || clk_ctrl_o.lp_osc_en || clk_ctrl_o.ext_osc_en)
      else $error("Timer zero wake not taken");
   AST_WAKE_COUNT: assert property (state_q == ST_WAKE ##1 state_q == ST_RUN // see R6 see R13
      |-> $past(wake_ticks_q) >= CK_SLEEP)
      else $error("Wake ended before six oscillator cycles");
   AST_SUT_LEGAL: assert property (state_q == ST_BOOT && tmr_start && fuse_rstdis_q |-> dly_tgt != '0) // see R14
      else $error("Start-up code without delay used with reset pin disabled");
   AST_RC_SELECT: assert property ($past(state_q) == ST_RUN && $past(src_eff) == CLOCK_SOURCE_FUSE_RC // see R11
      |-> clk_ctrl_o.rc_osc_en && !clk_ctrl_o.lp_osc_en)
      else $error("RC oscillator not selected");
endmodule

// ### core/sleep_clk_pkg.sv
// Package: constants, codes and carrier types of the sleep and clock start-up controller
package sleep_clk_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned DLY_SHORT_NS  = 4_100_000;
   localparam int unsigned DLY_LONG_NS   = 65_000_000;
   localparam int unsigned DLY_SHORT_CYC = (DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DLY_LONG_CYC  = (DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DLY_W         = 24;
   localparam logic [4:0]  CK_SLEEP      = 5'h06;
   localparam logic [4:0]  CK_RESET      = 5'h0E;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL      = 8'h00;
   localparam logic [7:0]  ADR_STATUS    = 8'h04;
   localparam logic [7:0]  ADR_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  ADR_IRQ_MASK  = 8'h0C;
   localparam int unsigned CTRL_SM_LSB   = 0;
   localparam int unsigned CTRL_CLOCK_SOURCE_FIELD_LSB = 4;
   localparam int unsigned CTRL_STARTUP_TIME_FIELD_LSB = 8;
   localparam int unsigned CTRL_FLD_BIT  = 12;
   localparam int unsigned STAT_ST_LSB   = 0;
   localparam int unsigned STAT_MODE_LSB = 4;
   localparam int unsigned STAT_SRC_LSB  = 8;
   localparam int unsigned STAT_SUT_LSB  = 12;
   localparam int unsigned STAT_DIV8_BIT = 14;
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_SLEEP     = 0;
   localparam int unsigned IRQ_WAKE      = 1;
   localparam int unsigned IRQ_RSVD      = 2;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  MODE_PDOWN    = 2'h2;
   localparam logic [1:0]  MODE_PSAVE    = 2'h3;
   localparam logic [3:0]  CLOCK_SOURCE_FUSE_RC      = 4'h2;
   localparam logic [3:0]  CLOCK_SOURCE_FUSE_LP      = 4'h3;
   localparam logic [1:0]  SUT_FAST      = 2'h0;
   localparam logic [1:0]  SUT_SHORT     = 2'h1;
   localparam logic [1:0]  SUT_LONG      = 2'h2;
   localparam logic [1:0]  SUT_RSVD      = 2'h3;
   localparam logic [3:0]  CLOCK_SOURCE_FUSE_RESET   = CLOCK_SOURCE_FUSE_RC;
   localparam logic [1:0]  SUT_RESET     = SUT_LONG;
   localparam logic [1:0]  SM_RESET      = 2'h0;
   localparam int unsigned WAKE_W        = 11;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_BOOT  = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_WAKE  = 4'b1000
   } pm_state_t;

   typedef struct packed {
      logic ext_rst;
      logic wdt_rst;
      logic bod_rst;
      logic wdt_irq;
      logic usi_start;
      logic external_interrupt_zero_lvl;
      logic external_interrupt_one_lvl;
      logic pin_change;
      logic t0_ovf;
      logic t0_cmp;
   } wake_src_t;

   typedef struct packed {
      logic core_clk_en;
      logic rc_osc_en;
      logic lp_osc_en;
      logic ext_osc_en;
      logic async_clk_en;
      logic div8_en;
   } clk_ctrl_t;

endpackage

// ### core/startup_timer.sv
// Start-up timer: oscillator cycles and optional reference-clock delay, counted side by side; done when both end
`timescale 1ns/1ps
module startup_timer
   import sleep_clk_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             start,
   input  wire logic [4:0]       ck_target,
   input  wire logic [DLY_W-1:0] dly_target,
   input  wire logic             osc_tick,
   output logic                  busy,
   output logic                  done
);
   logic [4:0]       ck_q;
   logic [4:0]       ck_tgt_q;
   logic [DLY_W-1:0] dly_q;
   logic [DLY_W-1:0] dly_tgt_q;
   logic             busy_q;
   logic             done_q;

   // Oscillator cycles are counted on ticks of the restarted oscillator, so a dead
   // oscillator never lets the core clock through
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ck_q      <= 5'h00;
         ck_tgt_q  <= 5'h00;
         dly_q     <= '0;
         dly_tgt_q <= '0;
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            ck_q      <= 5'h00;
            ck_tgt_q  <= ck_target;
            dly_q     <= '0;
            dly_tgt_q <= dly_target;
            busy_q    <= 1'b1;
         end else if (busy_q) begin
            if (osc_tick && ck_q != ck_tgt_q) begin
               ck_q <= ck_q + 5'h01;
            end
            if (dly_q != dly_tgt_q) begin
               dly_q <= dly_q + {{(DLY_W-1){1'b0}}, 1'b1};
            end
            if (ck_q == ck_tgt_q && dly_q == dly_tgt_q) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign busy = busy_q;
   assign done = done_q;
endmodule

// ### dv/osc_model.sv
// Oscillator model that drives the start-up tick input of the controller
`timescale 1ns/1ps
module osc_model
   import sleep_clk_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire clk_ctrl_t ctl,
   output logic           osc_toggle
);
   logic [1:0] div_q = 2'h0;
   logic       tog_q = 1'b0;

   // ----------------------------------------------------------------
   // Oscillator
   // ----------------------------------------------------------------
   // Stands still while every oscillator is off, as a stopped source would
   always_ff @(posedge ref_clk) begin
      if (ctl.rc_osc_en | ctl.lp_osc_en | ctl.ext_osc_en) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) begin
            tog_q <= ~tog_q;
         end
      end
   end
   assign osc_toggle = tog_q;
endmodule

// ### dv/tb_sleep_clk_ctrl.sv
// Self-checking testbench of the sleep and clock start-up controller
`timescale 1ns/1ps
module tb_sleep_clk_ctrl
   import sleep_clk_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep_exec = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, irq, tog, asel = 1'b1, ovf_ie = 1'b1, cmp_ie = 1'b1, gie = 1'b0;
   wake_src_t   wake = '0;
   clk_ctrl_t   cc;
   logic [1:0]  sutf = SUT_FAST;
   logic        rdis = 1'b0, d8 = 1'b0;
   int          n_fail = 0, checks = 0, t;

   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   sleep_clk_ctrl #(.DLY_SHORT_CYCLES(20), .DLY_LONG_CYCLES(40)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sleep_exec(sleep_exec), .timer0_async_select(asel), .timer0_ovf_ie(ovf_ie),
      .timer0_cmp_ie(cmp_ie), .global_ie(gie), .wake_src_i(wake), .osc_toggle_i(tog),
      .clock_source_fuse(CLOCK_SOURCE_FUSE_RC), .startup_time_fuse(sutf), .divide_by_eight_fuse(d8),
      .reset_pin_disable_fuse(rdis), .clk_ctrl_o(cc), .irq_o(irq));
   osc_model u_osc (.ref_clk(ref_clk), .ctl(cc), .osc_toggle(tog));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do @(posedge ref_clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wait_core(output int ticks);
      logic p;
      p = tog;
      ticks = 0;
      for (int i = 0; i < 3000 && cc.core_clk_en !== 1'b1; i++) begin
         @(negedge ref_clk);
         if (tog !== p) ticks++;
         p = tog;
      end
   endtask
   // Level sources are held four cycles so the synchroniser sees them
   task automatic pulse_src(input int b);
      @(posedge ref_clk) wake[b] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wake[b] <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic go_sleep(input logic [31:0] mode);
      wb(1'b1, ADR_CTRL, mode);
      @(posedge ref_clk) sleep_exec <= 1'b1;
      @(posedge ref_clk) sleep_exec <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic t_boot();
      wait_core(t);
      chk("boot ticks", 14, (t >= 14 && t <= 15) ? 14 : t);
      wb(1'b0, ADR_STATUS, 0);
      chk("status", 32'h0000_0202, q);
      wb(1'b0, 8'h40, 0);
      chk("unmapped", 32'h0, q);
      $display("test boot done");
   endtask
   task automatic t_pdown();
      wb(1'b1, ADR_IRQ_MASK, 32'h3);
      go_sleep(32'h2);
      chk("pd core", 0, cc.core_clk_en);
      chk("pd osc", 0, {cc.rc_osc_en, cc.ext_osc_en, cc.async_clk_en});
      chk("pd irq", 1, irq);
      gie <= 1'b1;
      pulse_src(1);
      chk("pd t0 ignored", 0, cc.core_clk_en);
      pulse_src(5);
      wait_core(t);
      chk("pd wake ticks", 6, (t >= 6 && t <= 7) ? 6 : t);
      @(negedge ref_clk);
      wb(1'b0, ADR_IRQ_STAT, 0);
      chk("irq stat", 32'h3, q);
      wb(1'b0, ADR_IRQ_STAT, 0);
      chk("irq cleared", 32'h0, q);
      chk("irq low", 0, irq);
      $display("test power-down done");
   endtask
   task automatic t_psave();
      gie <= 1'b0;
      go_sleep(32'h3);
      chk("ps async clk", 1, cc.async_clk_en);
      chk("ps core", 0, cc.core_clk_en);
      pulse_src(1);
      chk("ps no gie", 0, cc.core_clk_en);
      gie <= 1'b1;
      pulse_src(1);
      wait_core(t);
      chk("ps wake ticks", 6, (t >= 6 && t <= 7) ? 6 : t);
      go_sleep(32'h1);
      chk("mode 01 ignored", 1, cc.core_clk_en);
      $display("test power-save done");
   endtask
   // Mid-run reset with the reset pin disabled, so code 00 falls back to the short delay
   task automatic t_reboot();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      sutf <= SUT_FAST;
      rdis <= 1'b1;
      d8 <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_core(t);
      chk("reboot ticks", 14, (t >= 14 && t <= 15) ? 14 : t);
      chk("div8", 1, cc.div8_en);
      wb(1'b0, ADR_CTRL, 0);
      chk("ctrl reset", 32'h0000_0220, q);
      wb(1'b0, ADR_STATUS, 0);
      chk("reboot status", 32'h0000_5202, q);
      wb(1'b0, ADR_IRQ_STAT, 0);
      chk("code flag", 32'h4, q);
      go_sleep(32'h0000_1032);
      pulse_src(4);
      wait_core(t);
      chk("lp wake ticks", 6, (t >= 6 && t <= 7) ? 6 : t);
      chk("lp select", 32'h1, {cc.rc_osc_en, cc.lp_osc_en});
      $display("test reboot done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_boot();
      t_pdown();
      t_psave();
      t_reboot();
      tally_and_finish();
   end
endmodule
